//--- logic/pbm_pkg.sv
// constants and carrier types of the packet buffer and mode controller
// assumes one 100 MHz clock shared by the serial-port decoder and modem
package pbm_pkg;

    // buffer geometry and values after reset
    localparam int BUF_AW = 8;
    localparam int BUF_WORDS = 256;
    localparam int CLEAR_CYCLES = BUF_WORDS;
    localparam int RX_FIFO_DEPTH = 8;
    localparam logic [7:0] RX_BASE_RST = 8'h00;
    localparam logic [7:0] TX_BASE_RST = 8'h80;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] TX_LEN_RST = 8'h01;
    localparam logic [7:0] LAST_ADDR = 8'hFF;
    localparam logic [23:0] FRF_RST = 24'h000000;

    // operating modes, value read back in bits 2:0 of the mode register
    typedef enum logic [2:0] {
        SLEEP_MODE,
        STANDBY_MODE,
        TX_SYNTH_MODE,
        TX_MODE,
        RX_SYNTH_MODE,
        RX_CONTINUOUS_MODE,
        RX_ONE_PACKET_MODE,
        CHANNEL_ACTIVITY_MODE
    } pbm_mode_t;

    // registers reachable through the host command port
    typedef enum logic [3:0] {
        SEL_OPERATING_MODE,
        SEL_FRF_HI,
        SEL_FRF_MID,
        SEL_FRF_LO,
        SEL_TX_REGION_BASE,
        SEL_RX_REGION_BASE,
        SEL_ACCESS_POINTER,
        SEL_DATA_PORT,
        SEL_TX_PAYLOAD_LENGTH,
        SEL_RX_BYTE_COUNT,
        SEL_LAST_PACKET_START
    } pbm_sel_t;

    typedef struct packed {
        logic valid;
        logic write;
        pbm_sel_t sel;
        logic [7:0] data;
    } pbm_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pbm_rsp_t;

    // one received byte; first marks the first payload byte of a packet
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } pbm_rx_word_t;

    typedef struct packed {
        logic start;
        logic explicit_hdr;
        logic [7:0] length;
    } pbm_rx_pkt_t;

    typedef struct packed {
        logic done;
        logic crc_ok;
    } pbm_rx_end_t;

    typedef struct packed {
        logic xosc_on;
        logic baseband_on;
        logic synth_tx_on;
        logic synth_rx_on;
        logic rf_tx_on;
        logic rf_rx_on;
        logic pa_ramp;
        logic cad_run;
    } pbm_power_t;

endpackage

//--- logic/pbm_top.sv
// receive byte fifo and the packet buffer / operating mode controller
// assumes host commands arrive already decoded from the serial port, and
// that the modem datapath runs on clk_sys
`timescale 1ns/1ps

module pbm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic rdy_q;
    logic push;
    logic pop;

    // pointers wrap by width, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("pbm_fifo depth must be a power of two of at least 2");
    end

    assign push = in_valid & rdy_q;
    assign pop = out_valid & out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign in_ready = rdy_q;

    // occupancy after this cycle's push and pop
    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    // ready is registered so the source sees a flop, full stays honest
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end

    // storage has no reset; contents are only read behind a valid count
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
endmodule

// Functional notes
// [RULE1] config reads work in every mode; host writes in sleep or standby (code takes config writes in any mode)
// [RULE2] 256-byte packet buffer, reachable only with long-range modem selected
// [RULE3] buffer readable except in sleep; cleared on new entry to receive
// [RULE4] independent transmit and receive base pointers, any buffer address
// [RULE5] after reset receive base is 0x00 and transmit base is 0x80
// [RULE6] entering sleep clears the buffer; no buffer access succeeds in sleep
// [RULE7] contents survive other mode changes; words change only when written
// [RULE8] host loads the access pointer with a base before buffer access
// [RULE9] data port access uses the access pointer, then increments it
// [RULE10] transmit length sets bytes sent; explicit header loads receive count
// [RULE11] last packet start holds where the newest received packet begins
// [RULE12] payload bytes are stored even when the payload check fails
// [RULE13] long packets write on past the receive region into transmit area
// [RULE14] sleep keeps only port and registers; modem select set only in sleep
// [RULE15] standby runs oscillator and baseband, radio and synthesizers off
// [RULE16] synth modes lock the matching synthesizer with the radio off
// [RULE17] transmit ramps amplifier, sends one packet, returns to standby
// [RULE18] continuous receive runs until the host writes another mode
// [RULE19] single receive returns to standby after one valid packet
// [RULE20] channel activity mode looks for a long-range preamble
// [RULE21] a mode write moves directly to any mode
// [RULE22] carrier word is 24 bits, step is crystal over two to the nineteen
// [RULE23] access pointer and receive write address wrap to zero
// [RULE24] all register and buffer access comes via the host command port
module pbm_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pbm_pkg::pbm_cmd_t cmd,
    output pbm_pkg::pbm_rsp_t rsp,
    input wire logic rx_byte_valid,
    input wire pbm_pkg::pbm_rx_word_t rx_byte,
    output logic rx_byte_ready,
    input wire pbm_pkg::pbm_rx_pkt_t rx_pkt,
    input wire pbm_pkg::pbm_rx_end_t rx_end,
    input wire logic cad_done,
    output logic tx_byte_valid,
    output logic [7:0] tx_byte_data,
    input wire logic tx_byte_ready,
    output logic tx_done,
    output pbm_pkg::pbm_power_t power,
    output logic [23:0] carrier_word,
    output logic spread_modem_select,
    output pbm_pkg::pbm_mode_t mode,
    output logic buffer_busy
);
    import pbm_pkg::*;

    logic [7:0] buf_q [BUF_WORDS];
    pbm_mode_t mode_q;
    pbm_mode_t mode_d;
    logic modem_sel_q;
    logic [23:0] frf_q;
    logic [7:0] tx_base_q;
    logic [7:0] rx_base_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_len_q;
    logic [7:0] rx_cnt_q;
    logic [7:0] last_start_q;
    logic [7:0] rx_wr_q;
    logic clearing_q;
    logic [7:0] clr_addr_q;
    logic [7:0] tx_rd_q;
    logic [7:0] tx_left_q;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic tx_done_q;
    pbm_rsp_t rsp_q;
    pbm_power_t power_q;
    logic [7:0] reg_val;
    logic host_wr;
    logic host_data;
    logic buf_open;
    logic mode_wr;
    logic tx_fetch;
    logic tx_finish;
    logic auto_stby;
    logic enter_rx;
    logic enter_tx;
    logic start_clear;
    logic fifo_valid;
    logic fifo_ready;
    logic rx_store;
    pbm_rx_word_t fifo_word;

    function automatic logic is_rx(input pbm_mode_t m);
        return (m == RX_CONTINUOUS_MODE) || (m == RX_ONE_PACKET_MODE);
    endfunction

    // power plan per mode; the analog front end follows these levels
    function automatic pbm_power_t mode_power(input pbm_mode_t m);
        pbm_power_t p;
        p = '0;
        p.xosc_on = (m != SLEEP_MODE); // [RULE14]
        p.baseband_on = (m != SLEEP_MODE); // [RULE15]
        unique case (m)
            SLEEP_MODE, STANDBY_MODE: ;
            TX_SYNTH_MODE: p.synth_tx_on = 1'b1; // [RULE16]
            RX_SYNTH_MODE: p.synth_rx_on = 1'b1; // [RULE16]
            TX_MODE:
            begin
                p.synth_tx_on = 1'b1; // [RULE17]
                p.rf_tx_on = 1'b1;
                p.pa_ramp = 1'b1;
            end
            RX_CONTINUOUS_MODE, RX_ONE_PACKET_MODE:
            begin
                p.synth_rx_on = 1'b1;
                p.rf_rx_on = 1'b1;
            end
            CHANNEL_ACTIVITY_MODE:
            begin
                p.synth_rx_on = 1'b1; // [RULE20]
                p.rf_rx_on = 1'b1;
                p.cad_run = 1'b1;
            end
        endcase
        return p;
    endfunction

    // received bytes queue here while the buffer port is busy
    pbm_fifo #(
        .WIDTH($bits(pbm_rx_word_t)),
        .DEPTH(RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(rx_byte_valid),
        .in_data(rx_byte),
        .in_ready(rx_byte_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_word),
        .out_ready(fifo_ready)
    );

    // buffer port arbitration: clear, then host, then transmit, then receive
    assign host_wr = cmd.valid & cmd.write;
    assign buf_open = modem_sel_q & (mode_q != SLEEP_MODE) // [RULE2] [RULE6]
        & ~clearing_q;
    assign host_data = cmd.valid & (cmd.sel == SEL_DATA_PORT) // [RULE24]
        & buf_open;
    assign mode_wr = host_wr & (cmd.sel == SEL_OPERATING_MODE);
    assign tx_fetch = (mode_q == TX_MODE) & (tx_left_q != 8'h00) & buf_open
        & ~host_data & (~tx_valid_q | tx_byte_ready);
    assign tx_finish = (mode_q == TX_MODE) & (tx_left_q == 8'h00)
        & (~tx_valid_q | tx_byte_ready); // [RULE17]
    assign rx_store = fifo_valid & is_rx(mode_q) & buf_open & ~host_data
        & ~start_clear;
    // outside receive the queue is drained and dropped so it never wedges
    assign fifo_ready = rx_store | ~is_rx(mode_q) | ~modem_sel_q;

    // automatic return to standby when a one-shot activity completes
    assign auto_stby = tx_finish
        | ((mode_q == RX_ONE_PACKET_MODE) // [RULE19]
            & rx_end.done & rx_end.crc_ok)
        | ((mode_q == CHANNEL_ACTIVITY_MODE) & cad_done);

    // a host write of the mode wins over an automatic return
    always_comb
    begin
        mode_d = mode_q;
        if (mode_wr)
            mode_d = pbm_mode_t'(cmd.data[2:0]); // [RULE21]
        else if (auto_stby)
            mode_d = STANDBY_MODE;
    end

    // continuous receive only leaves on a host write, never by itself
    assign enter_rx = is_rx(mode_d) & ~is_rx(mode_q); // [RULE3] [RULE18]
    assign enter_tx = (mode_d == TX_MODE) & (mode_q != TX_MODE);
    assign start_clear = enter_rx
        | ((mode_d == SLEEP_MODE) & (mode_q != SLEEP_MODE)); // [RULE6]

    // mode and modem selection; modulation only switches from sleep
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q <= SLEEP_MODE;
            modem_sel_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            if (mode_wr && mode_q == SLEEP_MODE)
                modem_sel_q <= cmd.data[7]; // [RULE14]
        end
    end

    // configuration registers accept writes in any mode; timing is the host's
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            frf_q <= FRF_RST;
            tx_base_q <= TX_BASE_RST; // [RULE5]
            rx_base_q <= RX_BASE_RST; // [RULE5]
            tx_len_q <= TX_LEN_RST;
        end
        else if (host_wr)
        begin
            unique case (cmd.sel)
                SEL_FRF_HI: frf_q[23:16] <= cmd.data; // [RULE22]
                SEL_FRF_MID: frf_q[15:8] <= cmd.data;
                SEL_FRF_LO: frf_q[7:0] <= cmd.data;
                SEL_TX_REGION_BASE: tx_base_q <= cmd.data; // [RULE4]
                SEL_RX_REGION_BASE: rx_base_q <= cmd.data; // [RULE4]
                SEL_TX_PAYLOAD_LENGTH: tx_len_q <= cmd.data; // [RULE10]
                default: ;
            endcase
        end
    end

    // access pointer: loaded by the host, stepped by each data port access while the buffer is open
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ptr_q <= PTR_RST;
        else if (host_wr && cmd.sel == SEL_ACCESS_POINTER)
            ptr_q <= cmd.data; // [RULE8]
        else if (host_data)
            ptr_q <= ptr_q + 8'h01; // [RULE9] [RULE23]
    end

    // register read mux; buffer reads in sleep or while clearing give zero
    always_comb
    begin
        reg_val = 8'h00;
        unique case (cmd.sel)
            SEL_OPERATING_MODE: reg_val = {modem_sel_q, 4'h0, mode_q};
            SEL_FRF_HI: reg_val = frf_q[23:16];
            SEL_FRF_MID: reg_val = frf_q[15:8];
            SEL_FRF_LO: reg_val = frf_q[7:0];
            SEL_TX_REGION_BASE: reg_val = tx_base_q;
            SEL_RX_REGION_BASE: reg_val = rx_base_q;
            SEL_ACCESS_POINTER: reg_val = ptr_q;
            SEL_DATA_PORT: // [RULE3]
                reg_val = host_data ? buf_q[ptr_q] : 8'h00;
            SEL_TX_PAYLOAD_LENGTH: reg_val = tx_len_q;
            SEL_RX_BYTE_COUNT: reg_val = rx_cnt_q;
            SEL_LAST_PACKET_START: reg_val = last_start_q;
            default: reg_val = 8'h00;
        endcase
    end

    // one answer per read, one cycle later, in every mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= cmd.valid & ~cmd.write; // [RULE1]
            rsp_q.data <= (cmd.valid && !cmd.write) ? reg_val : rsp_q.data;
        end
    end

    // buffer clear walks all 256 words; reset starts one since reset is sleep
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clearing_q <= 1'b1;
            clr_addr_q <= 8'h00;
        end
        else if (start_clear)
        begin
            clearing_q <= 1'b1; // [RULE3] [RULE6]
            clr_addr_q <= 8'h00;
        end
        else if (clearing_q)
        begin
            clr_addr_q <= clr_addr_q + 8'h01;
            if (clr_addr_q == LAST_ADDR)
                clearing_q <= 1'b0;
        end
    end

    // single write port; words change only when written or cleared
    always_ff @(posedge clk_sys)
    begin
        if (clearing_q)
            buf_q[clr_addr_q] <= 8'h00;
        else if (host_data && cmd.write)
            buf_q[ptr_q] <= cmd.data; // [RULE7] [RULE9]
        else if (rx_store)
            buf_q[rx_wr_q] <= fifo_word.data; // [RULE12]
    end

    // receive write address: loaded on entry, never reset while receiving
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_wr_q <= RX_BASE_RST;
            last_start_q <= RX_BASE_RST;
        end
        else if (enter_rx)
            rx_wr_q <= rx_base_q;
        else if (rx_store)
        begin
            // no stop at the region end: runs on into the transmit area
            rx_wr_q <= rx_wr_q + 8'h01; // [RULE13] [RULE23]
            if (fifo_word.first)
                last_start_q <= rx_wr_q; // [RULE11]
        end
    end

    // received byte count follows the header; implicit header leaves it alone
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rx_cnt_q <= 8'h00;
        else if (rx_pkt.start && rx_pkt.explicit_hdr && is_rx(mode_q))
            rx_cnt_q <= rx_pkt.length; // [RULE10]
    end

    // transmit reader: sends the programmed number of bytes from the tx base
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_rd_q <= TX_BASE_RST;
            tx_left_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_done_q <= 1'b0;
        end
        else
        begin
            tx_done_q <= tx_finish;
            if (enter_tx)
            begin
                tx_rd_q <= tx_base_q;
                tx_left_q <= modem_sel_q ? tx_len_q : 8'h00; // [RULE10]
            end
            else if (tx_fetch)
            begin
                tx_rd_q <= tx_rd_q + 8'h01;
                tx_left_q <= tx_left_q - 8'h01;
            end
            if (tx_fetch)
            begin
                tx_valid_q <= 1'b1;
                tx_data_q <= buf_q[tx_rd_q];
            end
            else if (tx_byte_ready || mode_q != TX_MODE)
                tx_valid_q <= 1'b0;
        end
    end

    // power controls registered from the next mode so they track it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            power_q <= '0;
        else
            power_q <= mode_power(mode_d);
    end

    assign rsp = rsp_q;
    assign tx_byte_valid = tx_valid_q;
    assign tx_byte_data = tx_data_q;
    assign tx_done = tx_done_q;
    assign power = power_q;
    assign carrier_word = frf_q; // [RULE22]
    assign spread_modem_select = modem_sel_q;
    assign mode = mode_q;
    assign buffer_busy = clearing_q;
endmodule

//--- verification/pbm_top_asserts.sv
// checker of the packet buffer and mode controller ports
// assumes it is bound to pbm_top and sees only that module's ports
`timescale 1ns/1ps

module pbm_top_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pbm_pkg::pbm_cmd_t cmd,
    input wire pbm_pkg::pbm_rsp_t rsp,
    input wire logic tx_done,
    input wire pbm_pkg::pbm_power_t power,
    input wire logic [23:0] carrier_word,
    input wire logic spread_modem_select,
    input wire pbm_pkg::pbm_mode_t mode,
    input wire logic buffer_busy
);
    import pbm_pkg::*;

    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_read_answer: assert property (
        cmd.valid && !cmd.write |=> rsp.valid)
        else $error("read got no answer");
    a_no_spurious: assert property (
        rsp.valid |-> $past(cmd.valid) && !$past(cmd.write))
        else $error("answer without a read");
    a_sleep_data: assert property (cmd.valid && !cmd.write &&
        cmd.sel == SEL_DATA_PORT && mode == SLEEP_MODE |=> rsp.data == 8'h00)
        else $error("buffer readable in sleep");
    a_mode_write: assert property (cmd.valid && cmd.write &&
        cmd.sel == SEL_OPERATING_MODE |=> mode == $past(cmd.data[2:0]))
        else $error("mode write not taken");
    a_select_sleep: assert property ($changed(spread_modem_select) |->
        $past(mode) == SLEEP_MODE)
        else $error("modem select changed outside sleep");
    // the clear flag is set on the same edge as the mode; the check allows one cycle more
    a_sleep_clear: assert property ($changed(mode) &&
        mode == SLEEP_MODE |-> ##[0:1] buffer_busy)
        else $error("no clear on sleep entry");
    a_tx_return: assert property (tx_done |-> mode == STANDBY_MODE &&
        $past(mode) == TX_MODE)
        else $error("transmit end not back in standby");
    a_standby_power: assert property (mode == STANDBY_MODE |->
        power.xosc_on && power.baseband_on && !power.synth_tx_on &&
        !power.synth_rx_on && !power.rf_tx_on && !power.rf_rx_on)
        else $error("standby power wrong");
    a_synth_power: assert property (mode == TX_SYNTH_MODE ||
        mode == RX_SYNTH_MODE |-> !power.rf_tx_on && !power.rf_rx_on &&
        power.synth_tx_on == (mode == TX_SYNTH_MODE) &&
        power.synth_rx_on == (mode == RX_SYNTH_MODE))
        else $error("synth mode power wrong");
    a_carrier_hi: assert property (cmd.valid && cmd.write &&
        cmd.sel == SEL_FRF_HI |=> carrier_word[23:16] == $past(cmd.data))
        else $error("carrier high byte not taken");

    c_tx_done: cover property (tx_done);
    c_rx_done: cover property (mode == STANDBY_MODE &&
        $past(mode) == RX_ONE_PACKET_MODE);
    c_cad_done: cover property (mode == STANDBY_MODE &&
        $past(mode) == CHANNEL_ACTIVITY_MODE);
endmodule

bind pbm_top pbm_top_asserts u_pbm_top_asserts (.*);

//--- verification/pbm_host.sv
// host model: issues register port commands one at a time
// assumes a command is taken on the edge that sees valid high
`timescale 1ns/1ps

module pbm_host (
    input wire logic clk_sys,
    output pbm_pkg::pbm_cmd_t cmd,
    input wire pbm_pkg::pbm_rsp_t rsp
);
    import pbm_pkg::*;

    // port idle at time zero
    initial
    begin
        cmd = '0;
    end

    // callers write configuration only in sleep or standby
    task automatic xfer(input logic w, input pbm_sel_t sel,
        input logic [7:0] d, output logic [7:0] r);
    begin
        @(posedge clk_sys) #1;
        cmd = '{valid: 1'b1, write: w, sel: sel, data: d};
        @(posedge clk_sys) #1;
        // parked write and data lines show the inverse so stale data never matches
        cmd = '{valid: 1'b0, write: ~w, sel: sel, data: ~d};
        r = (rsp.valid === 1'b1) ? rsp.data : 8'bx;
    end
    endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench of the packet buffer and mode controller
// assumes pbm_top, pbm_host and the bound checker are compiled first
`timescale 1ns/1ps

module tb_top;
    import pbm_pkg::*;

    typedef struct packed {
        logic w;
        pbm_sel_t sel;
        logic [7:0] d;
        logic [7:0] e;
    } pbm_row_t;

    localparam int ROWS = 14;
    localparam int MAX_CYCLES = 4000;

    logic clk_sys;
    logic rst;
    pbm_cmd_t cmd;
    pbm_rsp_t rsp;
    logic rx_byte_valid;
    pbm_rx_word_t rx_byte;
    logic rx_byte_ready;
    pbm_rx_pkt_t rx_pkt;
    pbm_rx_end_t rx_end;
    logic cad_done;
    logic tx_byte_valid;
    logic [7:0] tx_byte_data;
    logic tx_byte_ready = 1'b0;
    logic tx_done;
    pbm_power_t power;
    logic [23:0] carrier_word;
    logic spread_modem_select;
    pbm_mode_t mode;
    logic buffer_busy;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int done_cnt = 0;
    logic [7:0] txq[$];
    // plain accesses: write flag, select, data, expected read
    pbm_row_t rows[ROWS] = '{
        '{1'b0, SEL_TX_REGION_BASE, 8'h00, 8'h80},
        '{1'b0, SEL_RX_REGION_BASE, 8'h00, 8'h00},
        '{1'b0, SEL_OPERATING_MODE, 8'h00, 8'h00},
        '{1'b0, SEL_DATA_PORT, 8'h00, 8'h00},
        '{1'b1, SEL_FRF_HI, 8'h12, 8'h00},
        '{1'b1, SEL_FRF_MID, 8'h34, 8'h00},
        '{1'b1, SEL_FRF_LO, 8'h56, 8'h00},
        '{1'b0, SEL_FRF_MID, 8'h00, 8'h34},
        '{1'b1, SEL_OPERATING_MODE, 8'h80, 8'h00},
        '{1'b0, SEL_OPERATING_MODE, 8'h00, 8'h80},
        '{1'b1, SEL_OPERATING_MODE, 8'h81, 8'h00},
        '{1'b0, SEL_OPERATING_MODE, 8'h00, 8'h81},
        '{1'b0, pbm_sel_t'(4'hB), 8'h00, 8'h00},
        '{1'b0, SEL_TX_PAYLOAD_LENGTH, 8'h00, 8'h01}};

    pbm_top u_pbm_top (.*);

    pbm_host u_pbm_host (.clk_sys(clk_sys), .cmd(cmd), .rsp(rsp));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // modulator stalls every other cycle to exercise the hold
    always @(posedge clk_sys)
        tx_byte_ready <= #1 ~tx_byte_ready;

    // sent bytes, end pulses, hang limit; falling edge sees settled handshake
    always @(negedge clk_sys)
    begin
        cycles++;
        if (tx_byte_valid && tx_byte_ready)
            txq.push_back(tx_byte_data);
        if (tx_done)
            done_cnt++;
        if (cycles == MAX_CYCLES)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask

    task automatic wr(input pbm_sel_t sel, input logic [7:0] d);
        logic [7:0] v;
    begin
        u_pbm_host.xfer(1'b1, sel, d, v);
    end
    endtask

    task automatic rdc(input pbm_sel_t sel, input logic [7:0] e);
        logic [7:0] v;
    begin
        u_pbm_host.xfer(1'b0, sel, 8'h00, v);
        chk(24'(v), 24'(e));
    end
    endtask

    // clear runs a fixed 256 cycles, so 400 is ample
    task automatic wait_free();
        int n;
    begin
        n = 0;
        while (buffer_busy !== 1'b0 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(24'(buffer_busy), 24'h0);
    end
    endtask

    task automatic send_rx(input logic first, input logic [7:0] d);
    begin
        @(posedge clk_sys) #1;
        rx_byte_valid = 1'b1;
        rx_byte = '{first: first, data: d};
        // ready is a flop: its value now is what the next edge samples
        while (rx_byte_ready !== 1'b1)
            @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
    end
    endtask

    // explicit header, n bytes stepping by 0x11, then the end pulse
    task automatic rx_packet(input logic [7:0] d0, input int n,
        input logic ok);
    begin
        @(posedge clk_sys) #1;
        rx_pkt = '{start: 1'b1, explicit_hdr: 1'b1, length: 8'(n)};
        @(posedge clk_sys) #1;
        rx_pkt = '0;
        for (int i = 0; i < n; i++)
            send_rx(i == 0, d0 + 8'(i * 17));
        repeat (4) @(posedge clk_sys);
        #1;
        rx_end = '{done: 1'b1, crc_ok: ok};
        @(posedge clk_sys) #1;
        rx_end = '0;
    end
    endtask

    task automatic stop_test();
    begin
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    initial
    begin
        rst = 1'b1;
        rx_byte_valid = 1'b0;
        rx_byte = '0;
        rx_pkt = '0;
        rx_end = '0;
        cad_done = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        wait_free();
        for (int i = 0; i < ROWS; i++)
        begin
            if (rows[i].w)
                wr(rows[i].sel, rows[i].d);
            else
                rdc(rows[i].sel, rows[i].e);
        end
        chk(carrier_word, 24'h123456);
        $display("test registers done");
        // pointer steps and wraps past the last location
        wr(SEL_ACCESS_POINTER, 8'hFE);
        for (int i = 0; i < 3; i++)
            wr(SEL_DATA_PORT, 8'hAA + 8'(i * 17));
        rdc(SEL_ACCESS_POINTER, 8'h01);
        wr(SEL_ACCESS_POINTER, 8'hFE);
        for (int i = 0; i < 3; i++)
            rdc(SEL_DATA_PORT, 8'hAA + 8'(i * 17));
        wr(SEL_OPERATING_MODE, 8'h82);
        wr(SEL_OPERATING_MODE, 8'h81);
        wr(SEL_ACCESS_POINTER, 8'hFF);
        rdc(SEL_DATA_PORT, 8'hBB);
        $display("test buffer done");
        wr(SEL_TX_REGION_BASE, 8'hFE);
        wr(SEL_TX_PAYLOAD_LENGTH, 8'h03);
        wr(SEL_OPERATING_MODE, 8'h83);
        for (int n = 0; n < 50 && done_cnt == 0; n++)
            @(posedge clk_sys);
        #1;
        chk(24'(txq.size()), 24'h3);
        for (int i = 0; i < 3; i++)
            chk(24'(txq[i]), 24'hAA + 24'(i * 17));
        chk(24'(mode), 24'(STANDBY_MODE));
        $display("test transmit done");
        wr(SEL_RX_REGION_BASE, 8'h7F);
        wr(SEL_OPERATING_MODE, 8'h86);
        wait_free();
        rx_packet(8'h11, 3, 1'b0);
        chk(24'(mode), 24'(RX_ONE_PACKET_MODE));
        rx_packet(8'h44, 1, 1'b1);
        chk(24'(mode), 24'(STANDBY_MODE));
        rdc(SEL_RX_BYTE_COUNT, 8'h01);
        rdc(SEL_LAST_PACKET_START, 8'h82);
        wr(SEL_ACCESS_POINTER, 8'h7F);
        for (int i = 0; i < 4; i++)
            rdc(SEL_DATA_PORT, 8'h11 + 8'(i * 17));
        wr(SEL_ACCESS_POINTER, 8'hFE);
        rdc(SEL_DATA_PORT, 8'h00);
        $display("test receive done");
        wr(SEL_OPERATING_MODE, 8'h87);
        @(posedge clk_sys) #1;
        cad_done = 1'b1;
        @(posedge clk_sys) #1;
        cad_done = 1'b0;
        chk(24'(mode), 24'(STANDBY_MODE));
        wr(SEL_OPERATING_MODE, 8'h85);
        wait_free();
        rx_packet(8'h55, 1, 1'b1);
        chk(24'(mode), 24'(RX_CONTINUOUS_MODE));
        wr(SEL_OPERATING_MODE, 8'h80);
        @(posedge clk_sys);
        #1;
        chk(24'(buffer_busy), 24'h1);
        rdc(SEL_DATA_PORT, 8'h00);
        wr(SEL_OPERATING_MODE, 8'h81);
        wait_free();
        wr(SEL_ACCESS_POINTER, 8'h7F);
        rdc(SEL_DATA_PORT, 8'h00);
        wr(SEL_OPERATING_MODE, 8'h00);
        rdc(SEL_OPERATING_MODE, 8'h80);
        wr(SEL_OPERATING_MODE, 8'h01);
        rdc(SEL_OPERATING_MODE, 8'h01);
        wr(SEL_ACCESS_POINTER, 8'h00);
        wr(SEL_DATA_PORT, 8'h5A);
        rdc(SEL_ACCESS_POINTER, 8'h00);
        $display("test modes done");
        stop_test();
    end
endmodule
